// [src/sms_startup_mode_selector.sv]
// Purpose: choose the operating mode once after reset from memory probe, fuses and strap
// Assumes: fuse values are static and on ref_clk; strap pin has its pull resistor fitted
// Notes: the probe runs on link_clk; selection is frozen until the next reset
`timescale 1ns/1ns
`include "sms_map.svh"

// Functional notes
// RULE1: probe the serial bus for a configuration memory before choosing mode.
// RULE2: check the ATA reset strap for manufacturing test request during selection.
// RULE3: with no memory answering, take configuration from fused values.
// RULE4: signature 4d4d selects legacy pinout and format on supporting variants.
// RULE5: signature 534b selects normal operation with descriptors from memory.
// RULE6: memory present with unknown signature selects manufacturing test mode.
// RULE7: all-zero fuses with no memory select manufacturing mode, default descriptors.
// RULE8: normal mode descriptors come from memory, else from fuses.
// RULE9: ATA reset pin pulled low at power-up selects manufacturing test mode.
// RULE10: manufacturing mode keeps USB running, ATA interface only partly active.
// RULE11: mode is decided once per reset and held until next reset.
module sms_startup_mode_selector #(
    parameter logic LEGACY_SUPPORT = 1'b1,
    parameter logic [19:0] PROBE_TIMEOUT_CYC = 20'(`SMS_PROBE_TIMEOUT_CYC)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    input wire logic ata_bus_reset_in_n,
    output logic ata_bus_reset_out_n,
    output logic ata_bus_reset_oe,
    input wire sms_pkg::sms_fuse_t fuse,
    output sms_pkg::sms_sel_t sel,
    output logic mode_valid,
    output logic usb_en
);
    sms_pkg::sms_state_t state;
    logic [19:0] cnt;
    logic start_tgl;
    logic done_tgl;
    logic [2:0] done_q;
    logic [1:0] strap_q;
    sms_pkg::sms_probe_t probe_link;
    sms_pkg::sms_probe_t probe_cap;
    logic probe_seen;
    logic fuse_blank;

    // ------------------------------------------------------------------------
    // mode decision
    // ------------------------------------------------------------------------
    // strap wins over everything; descriptor source still follows what was found
    function automatic sms_pkg::sms_sel_t decide(input sms_pkg::sms_probe_t p,
                                                input logic blank, input logic strap_low);
        sms_pkg::sms_sel_t s;
        s = '0;
        if (!p.present && !blank) begin
            s.mode = sms_pkg::MODE_NORMAL; // RULE3
            s.desc_src = sms_pkg::DESC_FUSE; // RULE8
        end else if (!p.present) begin
            s.mode = sms_pkg::MODE_MFG; // RULE7
            s.desc_src = sms_pkg::DESC_DEFAULT;
        end else if (p.signature == `SMS_SIG_LEGACY && LEGACY_SUPPORT) begin
            s.mode = sms_pkg::MODE_LEGACY; // RULE4
            s.desc_src = sms_pkg::DESC_EEPROM;
            s.legacy_pinout = 1'b1;
        end else if (p.signature == `SMS_SIG_NORMAL) begin
            s.mode = sms_pkg::MODE_NORMAL; // RULE5
            s.desc_src = sms_pkg::DESC_EEPROM; // RULE8
        end else begin
            s.mode = sms_pkg::MODE_MFG; // RULE6
            s.desc_src = sms_pkg::DESC_DEFAULT;
        end
        if (strap_low) begin
            s.mode = sms_pkg::MODE_MFG; // RULE2 RULE9
            s.legacy_pinout = 1'b0;
        end
        s.ata_full_en = (s.mode != sms_pkg::MODE_MFG); // RULE10
        return s;
    endfunction

    assign fuse_blank = (fuse == '0); // RULE7

    // ------------------------------------------------------------------------
    // crossings into ref_clk
    // ------------------------------------------------------------------------
    // strap pin and probe done toggle each pass two flops
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strap_q <= 2'h3;
            done_q <= 3'h0;
        end else begin
            strap_q <= {strap_q[0], ata_bus_reset_in_n};
            done_q <= {done_q[1:0], done_tgl};
        end
    end

    // ------------------------------------------------------------------------
    // startup sequencer
    // ------------------------------------------------------------------------
    // the reset pin stays released until the decision so the pull-down can be seen;
    // a dead link clock ends in the timeout and counts as no memory
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= sms_pkg::S_SETTLE;
            cnt <= 20'h00000;
            start_tgl <= 1'b0;
            probe_cap <= '0;
            probe_seen <= 1'b0;
        end else begin
            case (state)
                sms_pkg::S_SETTLE: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt == 20'(`SMS_STRAP_SETTLE_CYC - 1)) begin
                        state <= sms_pkg::S_PROBE;
                    end
                end
                sms_pkg::S_PROBE: begin
                    start_tgl <= ~start_tgl; // RULE1
                    cnt <= 20'h00000;
                    state <= sms_pkg::S_WAIT;
                end
                sms_pkg::S_WAIT: begin
                    cnt <= cnt + 20'h00001;
                    if (done_q[2] ^ done_q[1]) begin
                        probe_cap <= probe_link; // RULE1
                        probe_seen <= 1'b1;
                        state <= sms_pkg::S_DECIDE;
                    end else if (cnt == PROBE_TIMEOUT_CYC - 20'h00001) begin
                        probe_cap <= '0; // RULE3
                        probe_seen <= 1'b1;
                        state <= sms_pkg::S_DECIDE;
                    end
                end
                sms_pkg::S_DECIDE: begin
                    state <= sms_pkg::S_HOLD;
                end
                sms_pkg::S_HOLD: begin
                    state <= sms_pkg::S_HOLD; // RULE11
                end
                default: begin
                    state <= sms_pkg::S_SETTLE;
                end
            endcase
        end
    end

    // selection and pin outputs; written only in S_DECIDE
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel <= '0;
            mode_valid <= 1'b0;
            usb_en <= 1'b0;
            ata_bus_reset_out_n <= 1'b0;
            ata_bus_reset_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
        end else if (state == sms_pkg::S_DECIDE) begin
            sel <= decide(probe_cap, fuse_blank, !strap_q[1]); // RULE2 RULE11
            mode_valid <= 1'b1;
            usb_en <= 1'b1; // RULE10
            ata_bus_reset_out_n <= 1'b1;
            ata_bus_reset_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // link-side probe
    // ------------------------------------------------------------------------
    sms_i2c_probe u_probe (
        .link_clk(link_clk),
        .nrst(nrst),
        .start_tgl(start_tgl),
        .sda_in(sda_in),
        .sda_oe(sda_oe),
        .scl_oe(scl_oe),
        .done_tgl(done_tgl),
        .probe(probe_link)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_probe_first;
        @(posedge ref_clk) disable iff (!nrst) $rose(mode_valid) |-> probe_seen;
    endproperty
    a_probe_first: assert property (p_probe_first) else $error("mode before probe"); // RULE1

    property p_strap;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && !strap_q[1]) |=> sel.mode == sms_pkg::MODE_MFG;
    endproperty
    a_strap: assert property (p_strap) else $error("strap ignored"); // RULE9

    property p_fuse;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && strap_q[1] && !probe_cap.present && !fuse_blank)
            |=> (sel.mode == sms_pkg::MODE_NORMAL && sel.desc_src == sms_pkg::DESC_FUSE);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse source not used"); // RULE3

    property p_legacy;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && strap_q[1] && probe_cap.present && LEGACY_SUPPORT
             && probe_cap.signature == `SMS_SIG_LEGACY)
            |=> (sel.mode == sms_pkg::MODE_LEGACY && sel.legacy_pinout);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy not chosen"); // RULE4

    property p_normal;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && strap_q[1] && probe_cap.present
             && probe_cap.signature == `SMS_SIG_NORMAL)
            ##1 mode_valid [*2] |-> sel.desc_src == sms_pkg::DESC_EEPROM;
    endproperty
    a_normal: assert property (p_normal) else $error("memory descriptors not used"); // RULE5

    property p_badsig;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && probe_cap.present
             && probe_cap.signature != `SMS_SIG_NORMAL
             && !(LEGACY_SUPPORT && probe_cap.signature == `SMS_SIG_LEGACY))
            |=> sel.mode == sms_pkg::MODE_MFG;
    endproperty
    a_badsig: assert property (p_badsig) else $error("bad signature accepted"); // RULE6

    property p_blank;
        @(posedge ref_clk) disable iff (!nrst)
            (state == sms_pkg::S_DECIDE && !probe_cap.present && fuse_blank)
            |=> (sel.mode == sms_pkg::MODE_MFG && sel.desc_src == sms_pkg::DESC_DEFAULT);
    endproperty
    a_blank: assert property (p_blank) else $error("blank fuses accepted"); // RULE7

    property p_desc;
        @(posedge ref_clk) disable iff (!nrst)
            sel.mode == sms_pkg::MODE_NORMAL |-> sel.desc_src inside {sms_pkg::DESC_EEPROM,
                                                                   sms_pkg::DESC_FUSE};
    endproperty
    a_desc: assert property (p_desc) else $error("normal mode lacks descriptors"); // RULE8

    property p_mfg;
        @(posedge ref_clk) disable iff (!nrst)
            (mode_valid && sel.mode == sms_pkg::MODE_MFG) |-> (usb_en && !sel.ata_full_en);
    endproperty
    a_mfg: assert property (p_mfg) else $error("manufacturing mode outputs wrong"); // RULE10

    property p_hold;
        @(posedge ref_clk) disable iff (!nrst)
            mode_valid |=> (mode_valid && $stable(sel));
    endproperty
    a_hold: assert property (p_hold) else $error("selection changed"); // RULE11

endmodule

// [src/sms_map.svh]
// Purpose: constants for the startup mode selector (signatures, bus bytes, timing)
// Assumes: main clock 50 MHz, link clock period 12 ns
// Notes: times are kept in ns; cycle counts are derived from them
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// ----------------------------------------------------------------------------
// signatures and serial memory access bytes
// ----------------------------------------------------------------------------
`define SMS_SIG_LEGACY 16'h4d4d
`define SMS_SIG_NORMAL 16'h534b
`define SMS_EE_ADDR_WR 8'ha0
`define SMS_EE_ADDR_RD 8'ha1
`define SMS_EE_SIG_OFS 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SMS_REF_CLK_NS 20
`define SMS_LINK_CLK_NS 12
// one third of a serial bit; least time, so rounded up
`define SMS_I2C_PHASE_NS 2500
`define SMS_I2C_PHASE_CYC ((`SMS_I2C_PHASE_NS + `SMS_LINK_CLK_NS - 1) / `SMS_LINK_CLK_NS)
// strap settle with the reset pin released; least time, rounded up
`define SMS_STRAP_SETTLE_NS 1000
`define SMS_STRAP_SETTLE_CYC ((`SMS_STRAP_SETTLE_NS + `SMS_REF_CLK_NS - 1) / `SMS_REF_CLK_NS)
// longest wait for the probe; longest time, rounded down
`define SMS_PROBE_TIMEOUT_NS 10000000
`define SMS_PROBE_TIMEOUT_CYC (`SMS_PROBE_TIMEOUT_NS / `SMS_REF_CLK_NS)

`endif

// [src/sms_pkg.sv]
// Purpose: types shared by the startup mode selector files
// Assumes: nothing beyond the map header
// Notes: no values here, only shapes
package sms_pkg;

    typedef enum logic [1:0] {MODE_NONE, MODE_LEGACY, MODE_NORMAL, MODE_MFG} sms_mode_t;
    typedef enum logic [1:0] {DESC_NONE, DESC_EEPROM, DESC_FUSE, DESC_DEFAULT} sms_desc_t;
    typedef enum logic [2:0] {S_SETTLE, S_PROBE, S_WAIT, S_DECIDE, S_HOLD} sms_state_t;
    typedef enum logic [2:0] {I_IDLE, I_START, I_BYTE, I_ACK, I_RESTART, I_STOP, I_DONE} sms_i2c_t;

    // result of the serial memory probe
    typedef struct packed {
        logic present;
        logic [15:0] signature;
    } sms_probe_t;

    // fused identification values
    typedef struct packed {
        logic [15:0] vid;
        logic [15:0] pid;
        logic [15:0] did;
    } sms_fuse_t;

    // the selection that the rest of the chip follows
    typedef struct packed {
        sms_mode_t mode;
        sms_desc_t desc_src;
        logic legacy_pinout;
        logic ata_full_en;
    } sms_sel_t;

endpackage

// [src/sms_i2c_probe.sv]
// Purpose: serial memory probe on the link clock: random read of the 16-bit signature
// Assumes: open-drain bus with pull-ups; no clock stretching by the memory
// Notes: one probe per start toggle; signature stands before done_tgl flips, present is written on the same edge
`timescale 1ns/1ns
`include "sms_map.svh"

module sms_i2c_probe (
    input wire logic link_clk,
    input wire logic nrst,
    input wire logic start_tgl,
    input wire logic sda_in,
    output logic sda_oe,
    output logic scl_oe,
    output logic done_tgl,
    output sms_pkg::sms_probe_t probe
);
    logic [1:0] rst_q;
    logic [2:0] start_q;
    logic [1:0] sda_q;
    logic [7:0] cnt;
    logic tick;
    sms_pkg::sms_i2c_t st;
    logic [1:0] ph;
    logic [2:0] bitn;
    logic [2:0] step;
    logic [7:0] sh;
    logic addr_nack;
    logic rd;

    // ------------------------------------------------------------------------
    // crossings into the link domain
    // ------------------------------------------------------------------------
    // reset, start toggle and data pin each pass two flops before use
    always_ff @(posedge link_clk) begin
        rst_q <= {rst_q[0], nrst};
    end

    always_ff @(posedge link_clk) begin
        if (!rst_q[1]) begin
            start_q <= 3'h0;
            sda_q <= 2'h3;
        end else begin
            start_q <= {start_q[1:0], start_tgl};
            sda_q <= {sda_q[0], sda_in};
        end
    end

    // phase timer; every bit takes three phases
    always_ff @(posedge link_clk) begin
        if (!rst_q[1] || tick) begin
            cnt <= 8'(`SMS_I2C_PHASE_CYC - 1);
        end else begin
            cnt <= cnt - 8'h01;
        end
    end
    assign tick = (cnt == 8'h00);
    assign rd = (step >= 3'h3);

    // ------------------------------------------------------------------------
    // bus sequencer: start, addr wr, offset, restart, addr rd, two bytes, stop
    // ------------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!rst_q[1]) begin
            st <= sms_pkg::I_IDLE;
            ph <= 2'h0;
            bitn <= 3'h0;
            step <= 3'h0;
            sh <= 8'h00;
            addr_nack <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            done_tgl <= 1'b0;
            probe <= '0;
        end else if (st == sms_pkg::I_IDLE) begin
            if (start_q[2] ^ start_q[1]) begin // RULE1
                st <= sms_pkg::I_START;
                ph <= 2'h0;
                step <= 3'h0;
                addr_nack <= 1'b0;
            end
        end else if (st == sms_pkg::I_DONE) begin
            probe.present <= !addr_nack; // RULE1
            done_tgl <= ~done_tgl;
            st <= sms_pkg::I_IDLE;
        end else if (tick) begin
            ph <= ph + 2'h1;
            case (st)
                sms_pkg::I_START: begin
                    if (ph == 2'h0) begin
                        sda_oe <= 1'b1;
                    end else begin
                        scl_oe <= 1'b1;
                        sh <= `SMS_EE_ADDR_WR;
                        bitn <= 3'h7;
                        ph <= 2'h0;
                        st <= sms_pkg::I_BYTE;
                    end
                end
                sms_pkg::I_BYTE: begin
                    if (ph == 2'h0) begin
                        sda_oe <= rd ? 1'b0 : ~sh[7];
                    end else if (ph == 2'h1) begin
                        scl_oe <= 1'b0;
                    end else begin
                        scl_oe <= 1'b1;
                        sh <= {sh[6:0], sda_q[1]};
                        bitn <= bitn - 3'h1;
                        ph <= 2'h0;
                        if (bitn == 3'h0) begin
                            st <= sms_pkg::I_ACK;
                        end
                    end
                end
                sms_pkg::I_ACK: begin
                    if (ph == 2'h0) begin
                        sda_oe <= (step == 3'h3); // ack first read byte, not the last
                    end else if (ph == 2'h1) begin
                        scl_oe <= 1'b0;
                    end else begin
                        scl_oe <= 1'b1;
                        ph <= 2'h0;
                        bitn <= 3'h7;
                        step <= step + 3'h1;
                        if (!rd && sda_q[1]) begin
                            addr_nack <= (step == 3'h0);
                            probe.present <= 1'b0;
                            st <= sms_pkg::I_STOP;
                        end else if (step == 3'h0) begin
                            sh <= `SMS_EE_SIG_OFS;
                            st <= sms_pkg::I_BYTE;
                        end else if (step == 3'h1) begin
                            st <= sms_pkg::I_RESTART;
                        end else if (step == 3'h4) begin
                            probe.signature[7:0] <= sh;
                            st <= sms_pkg::I_STOP;
                        end else begin
                            if (step == 3'h3) begin
                                probe.signature[15:8] <= sh;
                            end
                            st <= sms_pkg::I_BYTE;
                        end
                    end
                end
                sms_pkg::I_RESTART: begin
                    if (ph == 2'h0) begin
                        sda_oe <= 1'b0;
                    end else if (ph == 2'h1) begin
                        scl_oe <= 1'b0;
                    end else if (ph == 2'h2) begin
                        sda_oe <= 1'b1;
                    end else begin
                        scl_oe <= 1'b1;
                        sh <= `SMS_EE_ADDR_RD;
                        bitn <= 3'h7;
                        st <= sms_pkg::I_BYTE;
                    end
                end
                sms_pkg::I_STOP: begin
                    if (ph == 2'h0) begin
                        sda_oe <= 1'b1;
                    end else if (ph == 2'h1) begin
                        scl_oe <= 1'b0;
                    end else begin
                        sda_oe <= 1'b0;
                        st <= sms_pkg::I_DONE;
                    end
                end
                default: begin
                    st <= sms_pkg::I_IDLE;
                end
            endcase
        end
    end

endmodule

// [dv/sms_ee_model.sv]
// Purpose: serial configuration memory answering the signature read
// Assumes: open-drain lines resolved by the bench; no clock stretching
// Notes: pull high means the data line is held low by the memory
`timescale 1ns/1ns
`include "sms_map.svh"

module sms_ee_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic present,
    input wire logic [15:0] sig,
    output logic pull
);
    int bitn = -1;
    int rcnt = 0;
    logic [7:0] sr = 8'h00;
    logic [7:0] cur = 8'h00;
    logic rd = 1'b0;
    logic act = 1'b0;
    logic first = 1'b0;

    initial pull = 1'b0;

    // start or restart: nothing addressed until the address byte is seen
    always @(negedge sda) if (scl) begin
        bitn = -1;
        rd = 1'b0;
        act = 1'b0;
        first = 1'b1;
        rcnt = 0;
    end

    // sample on the rising clock; a master nack ends the read
    always @(posedge scl) begin
        if (bitn < 8 && !rd)
            sr = {sr[6:0], sda};
        if (bitn == 8 && rd && sda)
            act = 1'b0;
    end

    // drive only while the clock is low, so no false start or stop is made
    always @(negedge scl) begin
        bitn = (bitn == 8) ? 0 : bitn + 1;
        pull = 1'b0;
        if (bitn == 8 && !rd) begin
            if (first) begin
                act = present && ({sr[7:1], 1'b0} == `SMS_EE_ADDR_WR);
                rd = act && sr[0];
            end
            first = 1'b0;
            pull = act;
        end else if (bitn < 8 && rd && act) begin
            if (bitn == 0) begin
                cur = (rcnt != 0) ? sig[7:0] : sig[15:8];
                rcnt++;
            end
            pull = !cur[7 - bitn];
        end
    end
endmodule

// [dv/test_startup_mode_selector.sv]
// Purpose: self-checking bench for the startup mode selector
// Assumes: pull-ups on both serial lines and on the ATA reset pin
// Notes: each scenario resets the block and waits for one decision
`timescale 1ns/1ns

`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end

module test_startup_mode_selector;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic strap_n = 1'b1;
    logic pres = 1'b0;
    logic [15:0] sig = 16'h0000;
    sms_pkg::sms_fuse_t fuse = '0;
    sms_pkg::sms_sel_t sel;
    logic sda_out, sda_oe, scl_out, scl_oe, rst_out_n, rst_oe, mode_valid, usb_en, pull;
    int fails = 0;
    int compares = 0;
    int scl_n = 0;

    // wire levels: a released line floats up through its pull-up
    wire sda_w = !(sda_oe === 1'b1) && !pull;
    wire scl_w = !(scl_oe === 1'b1);
    wire rst_w = (rst_oe === 1'b1) ? rst_out_n : strap_n;

    always #10 ref_clk = ~ref_clk;
    initial #3 forever #6 link_clk = ~link_clk;
    always @(negedge scl_w) scl_n++;

    sms_startup_mode_selector #(
        .LEGACY_SUPPORT(1'b1),
        .PROBE_TIMEOUT_CYC(20'h30d40)
    ) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
        .ata_bus_reset_in_n(rst_w), .ata_bus_reset_out_n(rst_out_n),
        .ata_bus_reset_oe(rst_oe), .fuse(fuse), .sel(sel), .mode_valid(mode_valid),
        .usb_en(usb_en)
    );

    sms_ee_model u_ee (.scl(scl_w), .sda(sda_w), .present(pres), .sig(sig), .pull(pull));

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // reset with the given board, then wait for the decision under a bound
    task automatic run(input logic p, input logic [15:0] s, input logic [47:0] f,
                       input logic st);
        int n;
        @(posedge ref_clk) #1;
        nrst = 1'b0;
        pres = p;
        sig = s;
        fuse = f;
        strap_n = st;
        repeat (4) @(posedge ref_clk);
        #1 nrst = 1'b1;
        `CHK("reset outputs", 10'h000, {mode_valid, usb_en, rst_oe, rst_out_n, sel})
        scl_n = 0;
        n = 0;
        // look just after the edge so the flop outputs have settled
        while (mode_valid !== 1'b1 && n < 20000) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (mode_valid !== 1'b1) begin
            `CHK("mode_valid", 1'b1, mode_valid)
            summarize();
        end
    endtask

    // compare the selection, then disturb the pins and see it held
    task automatic check(input sms_pkg::sms_mode_t m, input sms_pkg::sms_desc_t d,
                         input logic lp);
        sms_pkg::sms_sel_t e;
        e = '{mode: m, desc_src: d, legacy_pinout: lp,
              ata_full_en: (m != sms_pkg::MODE_MFG)};
        `CHK("sel", e, sel)
        `CHK("usb_en", 1'b1, usb_en)
        `CHK("probe clocks", 1'b1, scl_n >= 9)
        `CHK("ata reset pin", 2'h3, {rst_oe, rst_out_n})
        `CHK("line outs", 2'h0, {sda_out, scl_out})
        strap_n = ~strap_n;
        fuse = ~fuse;
        repeat (50) @(posedge ref_clk);
        `CHK("sel held", e, sel)
    endtask

    task automatic t_normal();
        run(1'b1, 16'h534b, 48'h0001_0002_0003, 1'b1);
        check(sms_pkg::MODE_NORMAL, sms_pkg::DESC_EEPROM, 1'b0);
    endtask

    task automatic t_legacy();
        run(1'b1, 16'h4d4d, 48'h0001_0002_0003, 1'b1);
        check(sms_pkg::MODE_LEGACY, sms_pkg::DESC_EEPROM, 1'b1);
    endtask

    // one bit off the normal signature is still unknown
    task automatic t_bad();
        run(1'b1, 16'h534a, 48'h0001_0002_0003, 1'b1);
        check(sms_pkg::MODE_MFG, sms_pkg::DESC_DEFAULT, 1'b0);
    endtask

    task automatic t_fuse();
        run(1'b0, 16'h534b, 48'h0001_0002_0003, 1'b1);
        check(sms_pkg::MODE_NORMAL, sms_pkg::DESC_FUSE, 1'b0);
    endtask

    task automatic t_blank();
        run(1'b0, 16'h534b, 48'h0000_0000_0000, 1'b1);
        check(sms_pkg::MODE_MFG, sms_pkg::DESC_DEFAULT, 1'b0);
    endtask

    // strap low beats a good signature
    task automatic t_strap();
        run(1'b1, 16'h534b, 48'h0001_0002_0003, 1'b0);
        check(sms_pkg::MODE_MFG, sms_pkg::DESC_EEPROM, 1'b0);
    endtask

    initial begin
        t_normal();
        t_legacy();
        t_bad();
        t_fuse();
        t_blank();
        t_strap();
        summarize();
    end
endmodule
